// [design/line_delay_fifo.sv]
/*
 * Line delay buffer: 5048 bytes, written and read in address order,
 * each side paced by its own pin clock.
 * Assumes clk_sys runs well above both pin clocks (at least four
 * system cycles per pin clock period) so every pin edge is seen.
 */
// Notes on behaviour
// - store 5048 bytes, walked in ascending order
// - write and read sides run independently
// - controls sampled only at own clock rising
// - write byte taken at edge ending cycle
// - read byte driven after starting read edge
// - gate low: store byte, then step pointer
// - gate low: output byte, then step pointer
// - write gate high: no store, pointer holds
// - read gate high: no read, output released
// - write pointer wraps from 5047 to zero
// - write clear low at edge zeroes pointer
// - read clear low at edge zeroes pointer
// - clears work regardless of either gate
// - shared continuous clock gives one-line delay
// - pointer stays zero while clear held
`timescale 1ns/1ns

`include "line_fifo_consts.svh"

module line_delay_fifo #(
    parameter int DEPTH  = `LDF_DEPTH,
    parameter int ADDR_W = `LDF_ADDR_W
) (
    input  wire logic                clk_sys,
    input  wire logic                rst_b,
    input  wire logic                wr_clk_in,
    input  wire logic                wr_gate_n,
    input  wire logic                wr_ptr_clear_n,
    input  wire line_fifo_pkg::byte_t wr_data_in,
    input  wire logic                rd_clk_in,
    input  wire logic                rd_gate_n,
    input  wire logic                rd_ptr_clear_n,
    output line_fifo_pkg::byte_t     rd_data_out,
    output logic                     rd_data_oe_n
);
    import line_fifo_pkg::*;

    localparam logic [ADDR_W-1:0] LAST_ADDR = ADDR_W'(DEPTH - 1);
    localparam logic [ADDR_W-1:0] ZERO_ADDR = '0;

    // ****************************************************************
    // pointer step
    // ****************************************************************
    // one step forward with wrap, shared by both pointers
    function automatic logic [ADDR_W-1:0] ptr_step(input logic [ADDR_W-1:0] p);
        logic [ADDR_W-1:0] n;
        n = ZERO_ADDR;
        if (p != LAST_ADDR) begin
            n = ADDR_W'(p + 1'b1);
        end
        return n;
    endfunction : ptr_step

    // ****************************************************************
    // pin synchronisers
    // ****************************************************************
    wr_pins_t  wr_meta_q;
    wr_pins_t  wr_sync_q;
    logic      wr_clk_last_q;
    side_ctl_t rd_meta_q;
    side_ctl_t rd_sync_q;
    logic      rd_clk_last_q;
    wr_pins_t  wr_pins;
    side_ctl_t rd_pins;

    // data and controls travel in one bundle so they stay aligned
    assign wr_pins = '{ctl: '{clk: wr_clk_in, gate_n: wr_gate_n, clear_n: wr_ptr_clear_n},
                       data: wr_data_in};
    assign rd_pins = '{clk: rd_clk_in, gate_n: rd_gate_n, clear_n: rd_ptr_clear_n};

    // two stages per pin; idle levels are inactive high controls
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_meta_q     <= '{ctl: '{clk: 1'b0, gate_n: 1'b1, clear_n: 1'b1}, data: '0};
            wr_sync_q     <= '{ctl: '{clk: 1'b0, gate_n: 1'b1, clear_n: 1'b1}, data: '0};
            wr_clk_last_q <= 1'b0;
            rd_meta_q     <= '{clk: 1'b0, gate_n: 1'b1, clear_n: 1'b1};
            rd_sync_q     <= '{clk: 1'b0, gate_n: 1'b1, clear_n: 1'b1};
            rd_clk_last_q <= 1'b0;
        end else begin
            wr_meta_q     <= wr_pins;
            wr_sync_q     <= wr_meta_q;
            wr_clk_last_q <= wr_sync_q.ctl.clk;
            rd_meta_q     <= rd_pins;
            rd_sync_q     <= rd_meta_q;
            rd_clk_last_q <= rd_sync_q.clk;
        end
    end

    // ****************************************************************
    // pin clock edges
    // ****************************************************************
    logic wr_evt;
    logic rd_evt;

    // one-cycle enables, each side on its own pin clock
    assign wr_evt = wr_sync_q.ctl.clk & ~wr_clk_last_q;
    assign rd_evt = rd_sync_q.clk & ~rd_clk_last_q;

    // ****************************************************************
    // write side
    // ****************************************************************
    logic [ADDR_W-1:0] wr_ptr_d;
    logic [ADDR_W-1:0] wr_ptr_q;
    logic              mem_we;

    // controls looked at only on a write clock edge
    always_comb begin
        wr_ptr_d = wr_ptr_q;
        mem_we   = 1'b0;
        if (wr_evt) begin
            if (!wr_sync_q.ctl.clear_n) begin
                wr_ptr_d = ZERO_ADDR;
            end else if (!wr_sync_q.ctl.gate_n) begin
                mem_we   = 1'b1;
                wr_ptr_d = ptr_step(wr_ptr_q);
            end
            // gate high: nothing stored, pointer holds
        end
    end

    // pointer is defined at reset although the pins alone never need it
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wr_ptr_q <= ZERO_ADDR;
        end else begin
            wr_ptr_q <= wr_ptr_d;
        end
    end

    // ****************************************************************
    // read side
    // ****************************************************************
    logic [ADDR_W-1:0] rd_ptr_d;
    logic [ADDR_W-1:0] rd_ptr_q;
    logic              rd_oe_n_d;
    logic              rd_oe_n_q;
    logic              mem_re;

    // a clear cycle reads nothing; output enable follows the gate
    always_comb begin
        rd_ptr_d  = rd_ptr_q;
        rd_oe_n_d = rd_oe_n_q;
        mem_re    = 1'b0;
        if (rd_evt) begin
            rd_oe_n_d = rd_sync_q.gate_n;
            if (!rd_sync_q.clear_n) begin
                rd_ptr_d = ZERO_ADDR;
            end else if (!rd_sync_q.gate_n) begin
                mem_re   = 1'b1;
                rd_ptr_d = ptr_step(rd_ptr_q);
            end
        end
    end

    // outputs released at reset so nothing fights the bus
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rd_ptr_q  <= ZERO_ADDR;
            rd_oe_n_q <= 1'b1;
        end else begin
            rd_ptr_q  <= rd_ptr_d;
            rd_oe_n_q <= rd_oe_n_d;
        end
    end

    assign rd_data_oe_n = rd_oe_n_q;

    // ****************************************************************
    // storage
    // ****************************************************************
    // same address walk on both sides gives the one-line delay
    line_fifo_mem #(
        .DEPTH  (DEPTH),
        .ADDR_W (ADDR_W),
        .DATA_W (`LDF_DATA_W)
    ) u_mem (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .we      (mem_we),
        .waddr   (wr_ptr_q),
        .wdata   (wr_sync_q.data),
        .re      (mem_re),
        .raddr   (rd_ptr_q),
        .rdata   (rd_data_out)
    );

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    // a pin rise first sampled at one edge gives the edge enable two edges later;
    // the pin itself is watched so the first sync stage keeps a single reader
    sequence s_wr_pin_rise;
        !wr_clk_in ##1 wr_clk_in;
    endsequence
    sequence s_wr_evt_next;
        ##2 wr_evt;
    endsequence
    sequence s_rd_adv;
        rd_evt && rd_sync_q.clear_n && !rd_sync_q.gate_n;
    endsequence

    chk_wr_edge_seen : assert property (
        s_wr_pin_rise |-> s_wr_evt_next)
        else $error("write clock rise not turned into one edge event");

    chk_wr_ptr_step : assert property (
        (wr_evt && wr_sync_q.ctl.clear_n && !wr_sync_q.ctl.gate_n && wr_ptr_q != LAST_ADDR)
        |=> wr_ptr_q == $past(wr_ptr_q) + 1'b1)
        else $error("write pointer did not step after a write");

    chk_wr_ptr_wrap : assert property (
        (wr_evt && wr_sync_q.ctl.clear_n && !wr_sync_q.ctl.gate_n && wr_ptr_q == LAST_ADDR)
        |=> wr_ptr_q == ZERO_ADDR)
        else $error("write pointer did not wrap to zero");

    chk_wr_gate_hold : assert property (
        (wr_evt && wr_sync_q.ctl.clear_n && wr_sync_q.ctl.gate_n) |-> !mem_we ##1 $stable(wr_ptr_q))
        else $error("write happened with gate high");

    chk_no_edge_hold : assert property (
        (!wr_evt && !rd_evt) |=> $stable(wr_ptr_q) && $stable(rd_ptr_q) && $stable(rd_data_oe_n))
        else $error("state moved without a pin clock edge");

    chk_wr_clear_zero : assert property (
        (wr_evt && !wr_sync_q.ctl.clear_n) |-> !mem_we ##1 wr_ptr_q == ZERO_ADDR)
        else $error("write clear did not zero the pointer");

    chk_rd_clear_zero : assert property (
        (rd_evt && !rd_sync_q.clear_n) |=> rd_ptr_q == ZERO_ADDR && !$stable(rd_ptr_q) || rd_ptr_q == ZERO_ADDR)
        else $error("read clear did not zero the pointer");

    chk_clear_holds : assert property (
        (rd_ptr_q == ZERO_ADDR && !rd_sync_q.clear_n) |=> rd_ptr_q == ZERO_ADDR)
        else $error("read pointer left zero while clear held");

    chk_rd_advance : assert property (
        s_rd_adv |=> !rd_data_oe_n && rd_ptr_q == ptr_step($past(rd_ptr_q)))
        else $error("read did not drive output and step pointer");

    chk_rd_release : assert property (
        (rd_evt && rd_sync_q.gate_n) |-> !mem_re ##1 rd_data_oe_n &&
        rd_ptr_q == ($past(rd_sync_q.clear_n) ? $past(rd_ptr_q) : ZERO_ADDR))
        else $error("read gate high did not release the output");

    chk_rd_wrap : assert property (
        (s_rd_adv ##0 rd_ptr_q == LAST_ADDR) |=> rd_ptr_q == ZERO_ADDR)
        else $error("read pointer did not wrap to zero");

    chk_gate_ignores_clear : assert property (
        (wr_evt && !wr_sync_q.ctl.clear_n && !wr_sync_q.ctl.gate_n) |=> wr_ptr_q == ZERO_ADDR)
        else $error("clear lost while write gate active");

endmodule : line_delay_fifo

// [common/line_fifo_consts.svh]
/*
 * Constants of the line delay buffer: geometry, addresses and timing.
 * Assumes inclusion by bare name; holds definitions only.
 */
`ifndef LINE_FIFO_CONSTS_SVH
`define LINE_FIFO_CONSTS_SVH

// ****************************************************************
// geometry
// ****************************************************************
`define LDF_DEPTH       5048
`define LDF_DATA_W      8
`define LDF_ADDR_W      13
`define LDF_LAST_ADDR   5047
`define LDF_ZERO_ADDR   13'h0000
`define LDF_ZERO_BYTE   8'h00

// ****************************************************************
// timing
// ****************************************************************
`define LDF_CLK_NS      10
// least write-to-read gap kept by the far side, rounded up to cycles
`define LDF_GAP_NS      470
`define LDF_GAP_CYC     ((`LDF_GAP_NS + `LDF_CLK_NS - 1) / `LDF_CLK_NS)
// least delay in pin cycles for the two pin cycle times
`define LDF_MIN_DLY_25  21
`define LDF_MIN_DLY_35  15

`endif

// [common/line_fifo_pkg.sv]
/*
 * Types of the line delay buffer: data byte and per-side pin groups.
 * Assumes line_fifo_consts.svh is on the include path.
 */
`include "line_fifo_consts.svh"

package line_fifo_pkg;

    typedef logic [`LDF_DATA_W-1:0] byte_t;
    typedef logic [`LDF_ADDR_W-1:0] addr_t;

    // control pins of one side, all active low but the clock
    typedef struct packed {
        logic clk;
        logic gate_n;
        logic clear_n;
    } side_ctl_t;

    // write side pins travel together so they stay aligned in the sync
    typedef struct packed {
        side_ctl_t ctl;
        byte_t     data;
    } wr_pins_t;

endpackage : line_fifo_pkg

// [design/line_fifo_mem.sv]
/*
 * Storage array of the line delay buffer, one write and one read port.
 * Assumes both ports are enabled by the caller on clk_sys only.
 */
`timescale 1ns/1ns

`include "line_fifo_consts.svh"

module line_fifo_mem #(
    parameter int DEPTH  = `LDF_DEPTH,
    parameter int ADDR_W = `LDF_ADDR_W,
    parameter int DATA_W = `LDF_DATA_W
) (
    input  wire logic              clk_sys,
    input  wire logic              rst_b,
    input  wire logic              we,
    input  wire logic [ADDR_W-1:0] waddr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              re,
    input  wire logic [ADDR_W-1:0] raddr,
    output logic      [DATA_W-1:0] rdata
);
    import line_fifo_pkg::*;

    // ****************************************************************
    // array and read register
    // ****************************************************************
    // no reset on the array: contents are undefined until written
    logic [DATA_W-1:0] mem_q [DEPTH];
    logic [DATA_W-1:0] rdata_d;
    logic [DATA_W-1:0] rdata_q;

    // read byte is taken only on a read event, else it holds
    always_comb begin
        rdata_d = rdata_q;
        if (re) begin
            rdata_d = mem_q[raddr];
        end
    end

    // store byte at write address
    always_ff @(posedge clk_sys) begin
        if (we) begin
            mem_q[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rdata_q <= '0;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata = rdata_q;

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [ADDR_W-1:0] last_addr_q;
    logic [DATA_W-1:0] last_data_q;
    logic              last_vld_q;

    // remembers the latest write for a read-back check
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            last_vld_q  <= 1'b0;
            last_addr_q <= '0;
            last_data_q <= '0;
        end else if (we) begin
            last_vld_q  <= 1'b1;
            last_addr_q <= waddr;
            last_data_q <= wdata;
        end
    end

    chk_mem_read_back : assert property (@(posedge clk_sys) disable iff (!rst_b)
        (re && !we && last_vld_q && raddr == last_addr_q) |=> rdata == last_data_q)
        else $error("read does not return the byte last written there");

endmodule : line_fifo_mem

// [tb/far_side_model.sv]
/*
 * Far side of the line delay buffer: the writing logic and the reading
 * logic, one pin cycle at a time through the task cycle.
 * Assumes clk_sys runs at eleven times the pin rate; the bench calls cycle.
 */
`timescale 1ns/1ns

`include "line_fifo_consts.svh"

module far_side_model (
    input  wire logic                 clk_sys,
    output line_fifo_pkg::side_ctl_t  wr_ctl,
    output line_fifo_pkg::byte_t      wr_data,
    output line_fifo_pkg::side_ctl_t  rd_ctl,
    input  wire line_fifo_pkg::byte_t rd_data,
    input  wire logic                 rd_oe_n
);
    import line_fifo_pkg::*;

    // ****************************************************************
    // idle pins
    // ****************************************************************
    // pin clocks low, gates and clears released
    initial begin
        wr_ctl  = 3'h3;
        wr_data = 8'h00;
        rd_ctl  = 3'h3;
    end

    // ****************************************************************
    // one pin cycle
    // ****************************************************************
    // a side whose enable is low keeps its clock still; levels stand
    // four system cycles before the rise and six after it
    task automatic cycle(input logic we, input logic wg, input logic wcl, input byte_t wd,
                         input logic re, input logic rg, input logic rcl,
                         output byte_t rd, output logic oe_n);
        @(posedge clk_sys);
        #1;
        if (we) begin
            wr_ctl.gate_n  = wg;
            wr_ctl.clear_n = wcl;
            wr_data        = wd;
        end
        if (re) begin
            rd_ctl.gate_n  = rg;
            rd_ctl.clear_n = rcl;
        end
        repeat (4) @(posedge clk_sys);
        #1;
        wr_ctl.clk = we;
        rd_ctl.clk = re;
        repeat (6) @(posedge clk_sys);
        #1;
        rd     = rd_data;
        oe_n   = rd_oe_n;
        wr_ctl = 3'h3;
        rd_ctl = 3'h3;
        // released data lines must not keep the last byte
        wr_data = ~wr_data;
    endtask : cycle

    // ****************************************************************
    // write-to-read gap
    // ****************************************************************
    // half a pin cycle plus the gap, with margin for the sync delay
    task automatic settle();
        repeat (`LDF_GAP_CYC + 10) @(posedge clk_sys);
    endtask : settle

endmodule : far_side_model

// [tb/tb.sv]
/*
 * Self-checking bench of the line delay buffer, with a small depth.
 * Assumes the package and far_side_model are compiled first.
 */
`timescale 1ns/1ns

module tb;
    import line_fifo_pkg::*;

    localparam int DEPTH = 16;

    logic      clk_sys = 1'b0;
    logic      rst_b   = 1'b0;
    side_ctl_t wr_ctl;
    side_ctl_t rd_ctl;
    byte_t     wr_data;
    byte_t     rd_data_out;
    logic      rd_data_oe_n;
    byte_t     rd_b;
    logic      oe_b;
    int        n_mismatch = 0;
    int        compares   = 0;

    // ****************************************************************
    // clock, design and far side
    // ****************************************************************
    always #5 clk_sys = ~clk_sys;

    line_delay_fifo #(.DEPTH(DEPTH), .ADDR_W(4)) u_dut (
        .clk_sys        (clk_sys),
        .rst_b          (rst_b),
        .wr_clk_in      (wr_ctl.clk),
        .wr_gate_n      (wr_ctl.gate_n),
        .wr_ptr_clear_n (wr_ctl.clear_n),
        .wr_data_in     (wr_data),
        .rd_clk_in      (rd_ctl.clk),
        .rd_gate_n      (rd_ctl.gate_n),
        .rd_ptr_clear_n (rd_ctl.clear_n),
        .rd_data_out    (rd_data_out),
        .rd_data_oe_n   (rd_data_oe_n)
    );

    far_side_model u_far (
        .clk_sys (clk_sys),
        .wr_ctl  (wr_ctl),
        .wr_data (wr_data),
        .rd_ctl  (rd_ctl),
        .rd_data (rd_data_out),
        .rd_oe_n (rd_data_oe_n)
    );

    // ****************************************************************
    // checking and closing
    // ****************************************************************
    task automatic check(input byte_t seen, input byte_t exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    // ****************************************************************
    // scenarios
    // ****************************************************************
    // output released right after reset
    task automatic t_reset();
        check(rd_data_out, 8'h00);
        check({7'h00, rd_data_oe_n}, 8'h01);
        $display("test reset done");
    endtask : t_reset

    // overfill by two so both pointers wrap
    task automatic t_wrap();
        int j;
        u_far.cycle(1, 1, 0, 8'h00, 1, 1, 0, rd_b, oe_b);
        for (int i = 0; i < DEPTH + 2; i++) begin
            u_far.cycle(1, 0, 1, byte_t'(8'ha0 + i), 0, 1, 1, rd_b, oe_b);
        end
        u_far.settle();
        for (int i = 0; i < DEPTH + 2; i++) begin
            u_far.cycle(0, 1, 1, 8'h00, 1, 0, 1, rd_b, oe_b);
            j = i % DEPTH;
            check(rd_b, (j < 2) ? byte_t'(8'ha0 + DEPTH + j) : byte_t'(8'ha0 + j));
            check({7'h00, oe_b}, 8'h00);
        end
        $display("test wrap done");
    endtask : t_wrap

    // clear cycle and high gates must store and read nothing
    task automatic t_gates();
        u_far.cycle(1, 0, 0, 8'hc3, 1, 1, 0, rd_b, oe_b);
        u_far.cycle(1, 0, 1, 8'h11, 0, 1, 1, rd_b, oe_b);
        u_far.cycle(1, 1, 1, 8'hee, 0, 1, 1, rd_b, oe_b);
        u_far.cycle(1, 0, 1, 8'h22, 0, 1, 1, rd_b, oe_b);
        u_far.settle();
        u_far.cycle(0, 1, 1, 8'h00, 1, 0, 1, rd_b, oe_b);
        check(rd_b, 8'h11);
        u_far.cycle(0, 1, 1, 8'h00, 1, 1, 1, rd_b, oe_b);
        check({7'h00, oe_b}, 8'h01);
        u_far.cycle(0, 1, 1, 8'h00, 1, 0, 1, rd_b, oe_b);
        check(rd_b, 8'h22);
        $display("test gates done");
    endtask : t_gates

    // clears held over several pin edges keep the pointers at zero
    task automatic t_clear_hold();
        for (int i = 0; i < 3; i++) begin
            u_far.cycle(1, 1, 0, 8'h77, 1, 0, 0, rd_b, oe_b);
            check({7'h00, oe_b}, 8'h00);
        end
        u_far.cycle(1, 0, 1, 8'h5a, 0, 1, 1, rd_b, oe_b);
        u_far.settle();
        u_far.cycle(0, 1, 1, 8'h00, 1, 0, 1, rd_b, oe_b);
        check(rd_b, 8'h5a);
        $display("test clear hold done");
    endtask : t_clear_hold

    // one shared pin clock, both gates low: a full line of delay
    task automatic t_line_delay();
        u_far.cycle(1, 0, 0, 8'h00, 1, 0, 0, rd_b, oe_b);
        for (int i = 0; i < 2 * DEPTH; i++) begin
            u_far.cycle(1, 0, 1, byte_t'(8'h30 + 3 * i), 1, 0, 1, rd_b, oe_b);
            if (i >= DEPTH) begin
                check(rd_b, byte_t'(8'h30 + 3 * (i - DEPTH)));
            end
        end
        $display("test line delay done");
    endtask : t_line_delay

    // ****************************************************************
    // main sequence and watchdog
    // ****************************************************************
    initial begin
        repeat (5) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset();
        t_wrap();
        t_gates();
        t_clear_hold();
        t_line_delay();
        complete_run();
    end

    // a hang counts as a mismatch and closes the run
    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        complete_run();
    end

endmodule : tb
